// File: common/swp_pkg.sv
// shared constants and types for the single-wire pin and chain controller
package swp_pkg;

    // clock and bus timing, times in ns as printed, cycles derived
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SAMP_STD_NS = 30000;
    localparam int T_SAMP_OD_NS = 3000;
    localparam int T_RST_STD_NS = 120000;
    localparam int T_RST_OD_NS = 16000;
    localparam int T_PDH_STD_NS = 30000;
    localparam int T_PDH_OD_NS = 3000;
    localparam int T_PDL_STD_NS = 120000;
    localparam int T_PDL_OD_NS = 12000;
    localparam int T_REH_NS = 5000;
    localparam int T_X_NS = 200;

    localparam int CNT_W = 16;
    typedef logic [CNT_W-1:0] swp_cnt_t;

    localparam swp_cnt_t SAMP_STD_CYC = 16'((T_SAMP_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam swp_cnt_t SAMP_OD_CYC = 16'((T_SAMP_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int RST_STD_CYC_DEF = (T_RST_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam swp_cnt_t RST_OD_CYC = 16'((T_RST_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam swp_cnt_t PDH_STD_CYC = 16'((T_PDH_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam swp_cnt_t PDH_OD_CYC = 16'((T_PDH_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PDL_STD_CYC_DEF = (T_PDL_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam swp_cnt_t PDL_OD_CYC = 16'((T_PDL_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam swp_cnt_t DLY_CYC = 16'((T_REH_NS + T_X_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // command and control codes
    localparam logic [7:0] CMD_PIN_READ = 8'hf5;
    localparam logic [7:0] CMD_PIN_WRITE = 8'ha5;
    localparam logic [7:0] CMD_CHAIN = 8'h99;
    localparam logic [7:0] CODE_CH_OFF = 8'h3c;
    localparam logic [7:0] CODE_CH_ON = 8'h5a;
    localparam logic [7:0] CODE_CH_DONE = 8'h96;
    localparam logic [7:0] BYTE_CONFIRM = 8'haa;
    localparam logic [7:0] BYTE_REJECT = 8'h00;

    // field positions of the status and output bytes
    localparam int STAT_A_PIN = 0;
    localparam int STAT_A_LAT = 1;
    localparam int STAT_B_PIN = 2;
    localparam int STAT_B_LAT = 3;
    localparam int OUT_A_BIT = 0;
    localparam int OUT_B_BIT = 1;
    localparam logic [2:0] MSB_IDX = 3'h7;

    typedef enum logic [2:0] {
        CH_OFF = 3'b001,
        CH_ON = 3'b010,
        CH_DONE = 3'b100
    } swp_chain_t;

    typedef enum logic [1:0] {
        PR_NONE = 2'b00,
        PR_WAIT = 2'b01,
        PR_LOW = 2'b10
    } swp_pres_t;

    typedef enum logic [10:0] {
        ST_ROM = 11'h001,
        ST_CMD = 11'h002,
        ST_RD = 11'h004,
        ST_WR_DATA = 11'h008,
        ST_WR_INV = 11'h010,
        ST_WR_CONF = 11'h020,
        ST_WR_STAT = 11'h040,
        ST_CH_CTRL = 11'h080,
        ST_CH_INV = 11'h100,
        ST_CH_RESP = 11'h200,
        ST_HALT = 11'h400
    } swp_state_t;

endpackage : swp_pkg

// File: core/swp_sync2.sv
// two-flop synchroniser with a constant reset value
`timescale 1ns/10ps
module swp_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : swp_sync2

// File: core/swp_bit_slave.sv
// bit-level slot handling: reset detect, presence, write sampling, read drive
`timescale 1ns/10ps
module swp_bit_slave import swp_pkg::*; #(
    parameter swp_cnt_t RST_STD_CYC = 16'(RST_STD_CYC_DEF),
    parameter swp_cnt_t PDL_STD_CYC = 16'(PDL_STD_CYC_DEF)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic line,
    input wire logic od,
    input wire logic tx_en,
    input wire logic tx_bit,
    output logic slot_end,
    output logic rx_bit,
    output logic bus_reset,
    output logic drive_low
);
    typedef struct packed {
        logic prev;
        logic low;
        logic rst_seen;
        swp_pres_t pres;
        swp_cnt_t cnt;
        logic drv;
        logic slot_end;
        logic rx_bit;
        logic bus_reset;
    } swp_bs_t;

    swp_bs_t cur_r;
    swp_bs_t cur_nxt;

    always_comb begin
        swp_cnt_t samp;
        swp_cnt_t rstc;
        swp_cnt_t pdh;
        swp_cnt_t pdl;
        samp = od ? SAMP_OD_CYC : SAMP_STD_CYC;
        rstc = od ? RST_OD_CYC : RST_STD_CYC;
        pdh = od ? PDH_OD_CYC : PDH_STD_CYC;
        pdl = od ? PDL_OD_CYC : PDL_STD_CYC;
        cur_nxt = cur_r;
        cur_nxt.prev = line;
        cur_nxt.slot_end = 1'b0;
        cur_nxt.bus_reset = 1'b0;
        if (cur_r.pres != PR_NONE) begin
            // presence answer after the master's reset pulse
            cur_nxt.cnt = cur_r.cnt + 16'h0001;
            if (cur_r.pres == PR_WAIT && cur_r.cnt >= pdh) begin
                cur_nxt.pres = PR_LOW;
                cur_nxt.cnt = '0;
                cur_nxt.drv = 1'b1;
            end else if (cur_r.pres == PR_LOW && cur_r.cnt >= pdl) begin
                cur_nxt.pres = PR_NONE;
                cur_nxt.drv = 1'b0;
            end
        end else if (cur_r.prev && !line) begin
            // every slot opens on the master's falling edge
            cur_nxt.low = 1'b1;
            cur_nxt.cnt = '0;
            cur_nxt.rx_bit = 1'b1;
            cur_nxt.drv = tx_en && !tx_bit;
        end else if (cur_r.low && !line) begin
            if (cur_r.cnt != rstc) begin
                cur_nxt.cnt = cur_r.cnt + 16'h0001;
            end
            if (cur_r.cnt == samp) begin
                cur_nxt.rx_bit = 1'b0;
                cur_nxt.drv = 1'b0;
            end
            // a long low resets the device
            if (cur_r.cnt == rstc - 16'h0001) begin
                cur_nxt.bus_reset = 1'b1;
                cur_nxt.rst_seen = 1'b1;
                cur_nxt.drv = 1'b0;
            end
        end else if (cur_r.low && line) begin
            cur_nxt.low = 1'b0;
            if (cur_r.rst_seen) begin
                cur_nxt.rst_seen = 1'b0;
                cur_nxt.pres = PR_WAIT;
                cur_nxt.cnt = '0;
            end else begin
                cur_nxt.slot_end = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= '{prev: 1'b1, low: 1'b0, rst_seen: 1'b0, pres: PR_NONE, cnt: '0,
                       drv: 1'b0, slot_end: 1'b0, rx_bit: 1'b1, bus_reset: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign slot_end = cur_r.slot_end;
    assign rx_bit = cur_r.rx_bit;
    assign bus_reset = cur_r.bus_reset;
    assign drive_low = cur_r.drv;
endmodule : swp_bit_slave

// File: core/swp_pio_chain.sv
// command level pin read, pin write and chain control behind the single-wire bus
//
// Contract
// - pin read sends status bytes until bus reset
// - chain ON/DONE: read allowed, latches read one
// - sample both pins during each byte's MSB
// - sample delay recovery time plus 0.2us
// - pin write ignored in chain ON or DONE
// - zero bit turns the pulldown on
// - latches update only on complement pair
// - new outputs after recovery time plus 0.2us
// - confirm good pair with AAh byte
// - sample during confirm MSB, send read-back status
// - write pairs loop until bus reset
// - power-up enters chain OFF
// - only 3Ch, 5Ah, 96h select OFF/ON/DONE
// - valid pair changes state, AAh; else 00h
// - idle high; long low resets device
// - reset, ROM byte, command, data order
// - master reset pulse, device presence pulse
// - master falling edge opens slots; open drain
// - OFF: commands own pins; ON: pullup, enable input
// - DONE: port_a pulled down, port_b unused
// - bytes travel least significant bit first
`timescale 1ns/10ps
module swp_pio_chain import swp_pkg::*; #(
    parameter swp_cnt_t RST_STD_CYC = 16'(RST_STD_CYC_DEF),
    parameter swp_cnt_t PDL_STD_CYC = 16'(PDL_STD_CYC_DEF)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    input wire logic overdrive_flag,
    input wire logic port_a_in,
    output logic port_a_out,
    output logic port_a_oe_n,
    output logic port_a_pullup,
    input wire logic port_b_in,
    output logic port_b_out,
    output logic port_b_oe_n
);
    typedef struct packed {
        swp_state_t st;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx;
        logic [7:0] first;
        swp_chain_t chain;
        logic lat_a;
        logic lat_b;
        logic [1:0] new_out;
        logic dly_act;
        logic dly_upd;
        swp_cnt_t dly_cnt;
        logic a_oe_n;
        logic b_oe_n;
        logic a_pull;
        logic dq_oe_n;
    } swp_core_t;

    swp_core_t cur_r;
    swp_core_t cur_nxt;

    logic rst_s;
    logic [2:0] pins_s;
    logic od_s;
    logic line_s;
    logic pin_a_s;
    logic pin_b_s;
    logic slot_end;
    logic rx_bit;
    logic bus_reset;
    logic drive_low;
    logic tx_en;
    logic [7:0] rx_byte;

    swp_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_rst (
        .clock(clock),
        .arst_n(rst_n),
        .d(1'b1),
        .q(rst_s)
    );

    swp_sync2 #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_pins (
        .clock(clock),
        .arst_n(rst_s),
        .d({port_b_in, port_a_in, dq_in}),
        .q(pins_s)
    );

    swp_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_od (
        .clock(clock),
        .arst_n(rst_s),
        .d(overdrive_flag),
        .q(od_s)
    );

    assign line_s = pins_s[0];
    assign pin_a_s = pins_s[1];
    assign pin_b_s = pins_s[2];

    swp_bit_slave #(.RST_STD_CYC(RST_STD_CYC), .PDL_STD_CYC(PDL_STD_CYC)) u_bit (
        .clock(clock),
        .rst_n(rst_s),
        .line(line_s),
        .od(od_s),
        .tx_en(tx_en),
        .tx_bit(cur_r.tx[cur_r.bit_cnt]),
        .slot_end(slot_end),
        .rx_bit(rx_bit),
        .bus_reset(bus_reset),
        .drive_low(drive_low)
    );

    // the device drives read slots only while it has a byte to send
    assign tx_en = (cur_r.st == ST_RD) || (cur_r.st == ST_WR_CONF) ||
                   (cur_r.st == ST_WR_STAT) || (cur_r.st == ST_CH_RESP);
    assign rx_byte = {rx_bit, cur_r.rx_sh[7:1]};

    function automatic logic [7:0] status_of(input logic a_pin, input logic b_pin,
                                             input logic la, input logic lb,
                                             input swp_chain_t ch);
        logic [3:0] lo;
        lo = '0;
        lo[STAT_A_PIN] = a_pin;
        lo[STAT_B_PIN] = b_pin;
        lo[STAT_A_LAT] = (ch == CH_OFF) ? la : 1'b1;
        lo[STAT_B_LAT] = (ch == CH_OFF) ? lb : 1'b1;
        return {~lo, lo};
    endfunction : status_of

    always_comb begin
        cur_nxt = cur_r;
        if (bus_reset) begin
            // abort: drop the command and any pending latch update
            cur_nxt.st = ST_ROM;
            cur_nxt.bit_cnt = '0;
            cur_nxt.dly_act = 1'b0;
        end else begin
            if (cur_r.dly_act) begin
                if (cur_r.dly_cnt == DLY_CYC - 16'h0001) begin
                    cur_nxt.dly_act = 1'b0;
                    if (cur_r.dly_upd) begin
                        if (cur_r.chain == CH_OFF) begin
                            cur_nxt.lat_a = cur_r.new_out[OUT_A_BIT];
                            cur_nxt.lat_b = cur_r.new_out[OUT_B_BIT];
                        end
                    end else begin
                        // both pins are taken in one sample
                        cur_nxt.tx = status_of(pin_a_s, pin_b_s, cur_r.lat_a, cur_r.lat_b,
                                               cur_r.chain);
                    end
                end else begin
                    cur_nxt.dly_cnt = cur_r.dly_cnt + 16'h0001;
                end
            end
            if (slot_end) begin
                cur_nxt.rx_sh = rx_byte;
                cur_nxt.bit_cnt = cur_r.bit_cnt + 3'h1;
                if (cur_r.bit_cnt == MSB_IDX) begin
                    case (cur_r.st)
                        ST_ROM: begin
                            // any selection byte addresses this device
                            cur_nxt.st = ST_CMD;
                        end
                        ST_CMD: begin
                            if (rx_byte == CMD_PIN_READ) begin
                                cur_nxt.st = ST_RD;
                                cur_nxt.dly_act = 1'b1;
                                cur_nxt.dly_upd = 1'b0;
                                cur_nxt.dly_cnt = '0;
                            end else if (rx_byte == CMD_PIN_WRITE) begin
                                cur_nxt.st = (cur_r.chain == CH_OFF) ? ST_WR_DATA : ST_HALT;
                            end else if (rx_byte == CMD_CHAIN) begin
                                cur_nxt.st = ST_CH_CTRL;
                            end else begin
                                cur_nxt.st = ST_HALT;
                            end
                        end
                        ST_RD: begin
                            cur_nxt.dly_act = 1'b1;
                            cur_nxt.dly_upd = 1'b0;
                            cur_nxt.dly_cnt = '0;
                        end
                        ST_WR_DATA: begin
                            cur_nxt.first = rx_byte;
                            cur_nxt.st = ST_WR_INV;
                        end
                        ST_WR_INV: begin
                            if (rx_byte == ~cur_r.first) begin
                                cur_nxt.new_out = cur_r.first[OUT_B_BIT:OUT_A_BIT];
                                cur_nxt.dly_act = 1'b1;
                                cur_nxt.dly_upd = 1'b1;
                                cur_nxt.dly_cnt = '0;
                                cur_nxt.tx = BYTE_CONFIRM;
                                cur_nxt.st = ST_WR_CONF;
                            end else begin
                                cur_nxt.st = ST_HALT;
                            end
                        end
                        ST_WR_CONF: begin
                            cur_nxt.dly_act = 1'b1;
                            cur_nxt.dly_upd = 1'b0;
                            cur_nxt.dly_cnt = '0;
                            cur_nxt.st = ST_WR_STAT;
                        end
                        ST_WR_STAT: begin
                            cur_nxt.st = ST_WR_DATA;
                        end
                        ST_CH_CTRL: begin
                            cur_nxt.first = rx_byte;
                            cur_nxt.st = ST_CH_INV;
                        end
                        ST_CH_INV: begin
                            cur_nxt.st = ST_CH_RESP;
                            cur_nxt.tx = BYTE_REJECT;
                            if (rx_byte == ~cur_r.first) begin
                                if (cur_r.first == CODE_CH_OFF) begin
                                    cur_nxt.chain = CH_OFF;
                                    cur_nxt.tx = BYTE_CONFIRM;
                                end else if (cur_r.first == CODE_CH_ON) begin
                                    cur_nxt.chain = CH_ON;
                                    cur_nxt.tx = BYTE_CONFIRM;
                                end else if (cur_r.first == CODE_CH_DONE) begin
                                    cur_nxt.chain = CH_DONE;
                                    cur_nxt.tx = BYTE_CONFIRM;
                                end
                            end
                        end
                        default: begin
                            cur_nxt.st = cur_r.st;
                        end
                    endcase
                end
            end
        end
        // pin drivers follow chain state and latches
        case (cur_nxt.chain)
            CH_ON: begin
                cur_nxt.a_oe_n = 1'b1;
                cur_nxt.b_oe_n = 1'b1;
                cur_nxt.a_pull = 1'b1;
            end
            CH_DONE: begin
                cur_nxt.a_oe_n = 1'b0;
                cur_nxt.b_oe_n = 1'b1;
                cur_nxt.a_pull = 1'b0;
            end
            default: begin
                cur_nxt.a_oe_n = cur_nxt.lat_a;
                cur_nxt.b_oe_n = cur_nxt.lat_b;
                cur_nxt.a_pull = 1'b0;
            end
        endcase
        cur_nxt.dq_oe_n = ~drive_low;
    end

    always_ff @(posedge clock or negedge rst_s) begin
        if (!rst_s) begin
            cur_r <= '{st: ST_ROM, bit_cnt: '0, rx_sh: '0, tx: '0, first: '0,
                       chain: CH_OFF, lat_a: 1'b1, lat_b: 1'b1, new_out: '1,
                       dly_act: 1'b0, dly_upd: 1'b0, dly_cnt: '0,
                       a_oe_n: 1'b1, b_oe_n: 1'b1, a_pull: 1'b0, dq_oe_n: 1'b1};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign dq_out = 1'b0;
    assign dq_oe_n = cur_r.dq_oe_n;
    assign port_a_out = 1'b0;
    assign port_b_out = 1'b0;
    assign port_a_oe_n = cur_r.a_oe_n;
    assign port_b_oe_n = cur_r.b_oe_n;
    assign port_a_pullup = cur_r.a_pull;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_s);

    logic samp_fire;
    assign samp_fire = cur_r.dly_act && !cur_r.dly_upd && !bus_reset &&
                       (cur_r.dly_cnt == DLY_CYC - 16'h0001);

    chk_status_compl: assert property (samp_fire |=> cur_r.tx[7:4] == ~cur_r.tx[3:0])
        else $error("status byte upper nibble not inverted");
    chk_chain_lat_ones: assert property (samp_fire && cur_r.chain != CH_OFF
        |=> cur_r.tx[STAT_A_LAT] && cur_r.tx[STAT_B_LAT])
        else $error("latch bits not one in chain state");
    chk_read_loops: assert property (cur_r.st == ST_RD && !bus_reset |=> cur_r.st == ST_RD)
        else $error("pin read loop left without bus reset");
    chk_write_ignored: assert property (cur_r.chain != CH_OFF
        |=> $stable({cur_r.lat_a, cur_r.lat_b}))
        else $error("latches changed outside chain off");
    chk_latch_cause: assert property ($changed({cur_r.lat_a, cur_r.lat_b})
        |-> $past(cur_r.dly_act && cur_r.dly_upd && cur_r.dly_cnt == DLY_CYC - 16'h0001))
        else $error("latch changed without checked pair and delay");
    chk_pulldown_pol: assert property (cur_r.chain == CH_OFF
        |-> port_a_oe_n == cur_r.lat_a && port_b_oe_n == cur_r.lat_b)
        else $error("pulldown does not follow latch");
    chk_chain_on_pins: assert property (cur_r.chain == CH_ON
        |-> port_a_pullup && port_a_oe_n && port_b_oe_n)
        else $error("chain on pin setup wrong");
    chk_chain_done_pin: assert property (cur_r.chain == CH_DONE
        |-> !port_a_oe_n && port_b_oe_n && !port_a_pullup)
        else $error("chain done pulldown missing");
    chk_chain_cause: assert property ($changed(cur_r.chain)
        |-> $past(cur_r.st == ST_CH_INV && slot_end) && cur_r.tx == BYTE_CONFIRM)
        else $error("chain state changed without valid pair");
    chk_bus_abort: assert property (bus_reset |=> cur_r.st == ST_ROM && !cur_r.dly_act)
        else $error("bus reset did not abort command");
    chk_chain_reset: assert property ($rose(rst_s) |-> cur_r.chain == CH_OFF)
        else $error("chain not off after reset");

    cov_read_byte: cover property (cur_r.st == ST_RD && samp_fire);
    cov_write_upd: cover property ($changed({cur_r.lat_a, cur_r.lat_b}));
    cov_chain_done: cover property (cur_r.chain == CH_DONE);
    cov_chain_reject: cover property (cur_r.st == ST_CH_RESP && cur_r.tx == BYTE_REJECT);
endmodule : swp_pio_chain

// File: bench/swp_master_model.sv
// bus master model: reset with presence sampling, byte writes and byte reads
`timescale 1ns/10ps
module swp_master_model (
    input wire logic clock,
    input wire logic dq,
    output logic drv_low
);
    localparam int ZLOW = 310;
    localparam int GAP = 530;
    initial drv_low = 1'b0; // released line idles high
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold
    // low time, presence sample point and tail depend on the speed under test
    task automatic bus_reset(input int t_low, input int t_smp, input int t_end,
                             output logic pres);
        drv_low <= 1'b1; // each transaction opens with a reset pulse
        hold(t_low);
        drv_low <= 1'b0;
        hold(t_smp);
        pres = dq;
        hold(t_end);
    endtask : bus_reset
    // short slots for ones keep the run short; zeros outlast the sample point
    task automatic write_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin // least significant bit first
            drv_low <= 1'b1; // every slot opens with a falling edge
            hold(b[i] ? 10 : ZLOW);
            drv_low <= 1'b0;
            hold(b[i] ? 20 : 10);
        end
    endtask : write_byte
    task automatic read_byte(output logic [7:0] b);
        // the device may still be sampling pins up to 520 cycles after the last msb
        hold(GAP);
        for (int i = 0; i < 8; i++) begin
            drv_low <= 1'b1;
            hold(10);
            drv_low <= 1'b0;
            hold(10);
            b[i] = dq;
            // a zero is held low by the device until its sample time is over
            hold(b[i] ? 10 : 300);
        end
    endtask : read_byte
endmodule : swp_master_model

// File: bench/tb.sv
// testbench driving pin read, pin write and chain commands over the bus
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb import swp_pkg::*;;
    logic clock, rst_n, od, drv_low, dq, dq_oe_n, pa_oe_n, pa_up, pb_oe_n;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    logic pres_std;
    // open-drain wires with pull-ups
    assign dq = ~drv_low & dq_oe_n;
    swp_master_model i_mst (.clock(clock), .dq(dq), .drv_low(drv_low));
    swp_pio_chain #(.RST_STD_CYC(16'h00c8), .PDL_STD_CYC(16'h0064)) i_dut (
        .clock(clock), .rst_n(rst_n), .dq_in(dq), .dq_out(), .dq_oe_n(dq_oe_n),
        .overdrive_flag(od), .port_a_in(pa_oe_n), .port_a_out(), .port_a_oe_n(pa_oe_n),
        .port_a_pullup(pa_up), .port_b_in(pb_oe_n), .port_b_out(), .port_b_oe_n(pb_oe_n));
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic open_cmd(input logic [7:0] cmd);
        logic pres;
        i_mst.bus_reset(1700, 800, 720, pres);
        `CHK("presence", 1'b0, pres)
        i_mst.write_byte(8'hff); // any selection byte precedes the command
        i_mst.write_byte(cmd);
    endtask : open_cmd
    task automatic rd(input string nm, input logic [7:0] e);
        logic [7:0] b;
        i_mst.read_byte(b);
        `CHK(nm, e, b)
    endtask : rd
    task automatic pair(input logic [7:0] d);
        i_mst.write_byte(d);
        i_mst.write_byte(~d);
    endtask : pair
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 95000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        rst_n <= 1'b0;
        od <= 1'b1;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        `CHK("a_idle", 1'b1, pa_oe_n)
        `CHK("a_pullup", 1'b0, pa_up)
        open_cmd(CMD_PIN_READ);
        rd("read0", 8'h0f);
        rd("read1", 8'h0f);
        open_cmd(CMD_PIN_WRITE);
        pair(8'hfe); // port_a on, unused bits sent as ones
        rd("confirm", BYTE_CONFIRM);
        rd("readback", 8'h3c);
        `CHK("a_on", 1'b0, pa_oe_n)
        pair(8'hfd);
        rd("confirm2", BYTE_CONFIRM);
        rd("readback2", 8'hc3);
        open_cmd(CMD_PIN_WRITE);
        i_mst.write_byte(8'hfc);
        i_mst.write_byte(8'h00);
        rd("bad_pair", 8'hff);
        `CHK("b_kept", 1'b0, pb_oe_n)
        open_cmd(CMD_CHAIN);
        pair(CODE_CH_ON);
        rd("chain_on", BYTE_CONFIRM);
        `CHK("on_pullup", 1'b1, pa_up)
        `CHK("on_b_free", 1'b1, pb_oe_n)
        open_cmd(CMD_PIN_READ);
        rd("read_on", 8'h0f);
        open_cmd(CMD_PIN_WRITE);
        pair(8'hfc);
        rd("write_on", 8'hff);
        `CHK("on_a_kept", 1'b1, pa_oe_n)
        open_cmd(CMD_CHAIN);
        pair(8'h11);
        rd("chain_bad", BYTE_REJECT);
        `CHK("bad_kept", 1'b1, pa_up)
        open_cmd(CMD_CHAIN);
        pair(CODE_CH_DONE);
        rd("chain_done", BYTE_CONFIRM);
        `CHK("done_a_low", 1'b0, pa_oe_n)
        `CHK("done_no_up", 1'b0, pa_up)
        // standard speed: short reset threshold, presence only after the long wait
        od <= 1'b0;
        i_mst.bus_reset(300, 3050, 150, pres_std);
        `CHK("pres_std", 1'b0, pres_std)
        end_of_test();
    end
endmodule : tb
